// file: logic/supervisor_pkg.sv
// Constants and carrier types for the host power and watchdog supervisor
package supervisor_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ        = 250_000_000;
  localparam int TICK_HZ       = 32;
  localparam int TICK_CYC      = CLK_HZ / TICK_HZ;
  localparam int PWM_HZ        = 100;
  localparam int PWM_STEPS     = 100;
  localparam int PWM_STEP_CYC  = CLK_HZ / (PWM_HZ * PWM_STEPS);
  localparam int HOLD_LONG_MS  = 4000;
  localparam int HOLD_SHORT_MS = 250;
  localparam int RST_PULSE_MS  = 1000;
  localparam int EXTEND_MS     = 5000;
  localparam int SEC_MS        = 1000;
  localparam logic [7:0] HOLD_LONG_TK  = 8'(HOLD_LONG_MS * TICK_HZ / 1000);
  localparam logic [7:0] HOLD_SHORT_TK = 8'(HOLD_SHORT_MS * TICK_HZ / 1000);
  localparam logic [7:0] RST_PULSE_TK  = 8'(RST_PULSE_MS * TICK_HZ / 1000);
  localparam logic [7:0] EXTEND_TK     = 8'(EXTEND_MS * TICK_HZ / 1000);
  localparam logic [4:0] SEC_TK        = 5'(SEC_MS * TICK_HZ / 1000 - 1);
  localparam logic [6:0] PWM_LAST      = 7'(PWM_STEPS - 1);
  // ---------------------------------------------------------------
  // Command and response codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_SWITCH   = 8'h1C;
  localparam logic [7:0] CMD_WDOG     = 8'h1D;
  localparam logic [7:0] CMD_READBACK = 8'h1E;
  localparam logic [7:0] CMD_TEXT     = 8'h1F;
  localparam logic [7:0] CMD_BAUD     = 8'h21;
  localparam logic [7:0] CMD_GPIO_SET = 8'h22;
  localparam logic [7:0] CMD_GPIO_GET = 8'h23;
  localparam logic [7:0] RSP_ACK      = 8'h40;
  localparam logic [7:0] RSP_ERR      = 8'hC0;
  // ---------------------------------------------------------------
  // Field positions, limits and reset values
  // ---------------------------------------------------------------
  localparam int SW_AUTO_POL = 0;
  localparam int SW_RST_INV  = 1;
  localparam int SW_PWR_INV  = 2;
  localparam int SW_BLANK    = 4;
  localparam int SW_KEY_RST  = 5;
  localparam int SW_KEY_ON   = 6;
  localparam int SW_KEY_OFF  = 7;
  localparam int RB_IDX_MASK = 7;
  localparam int RB_IDX_WD   = 8;
  localparam int RB_IDX_SRC  = 11;
  localparam int PIN_SENSE   = 1;
  localparam int PIN_PWR     = 2;
  localparam int PIN_RST     = 3;
  localparam int CFG_USER    = 3;
  localparam logic [4:0] RB_LEN     = 5'h0F;
  localparam logic [4:0] GET_LEN    = 5'h04;
  localparam logic [4:0] TEXT_MIN   = 5'h03;
  localparam logic [4:0] TEXT_MAX   = 5'h12;
  localparam logic [7:0] COL_MAX    = 8'h0F;
  localparam logic [7:0] ROW_MAX    = 8'h01;
  localparam logic [7:0] LVL_MAX    = 8'h64;
  localparam logic [7:0] CFG_MAX    = 8'h0F;
  localparam logic [2:0] DRV_HIZ    = 3'h2;
  localparam logic [7:0] SW_MASK_RST  = 8'h00;
  localparam logic [7:0] PULSE_RST    = 8'h20;
  localparam logic       SRC_RST      = 1'b1;
  localparam logic [3:0] GPIO_CFG_RST = 4'h2;
  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0]       kind;
    logic [4:0]       len;
    logic [17:0][7:0] data;
  } cmd_s;
  typedef struct packed {
    logic [7:0]       kind;
    logic [4:0]       len;
    logic [14:0][7:0] data;
  } rsp_s;
  typedef struct packed {
    logic [3:0][7:0] temp_mask;
    logic [7:0]      key_press;
    logic [7:0]      key_release;
    logic [7:0]      user_contrast;
    logic [7:0]      key_backlight;
    logic [7:0]      contrast;
    logic [7:0]      lcd_backlight;
  } misc_s;
  typedef struct packed {
    logic [3:0]       col;
    logic             row;
    logic [4:0]       count;
    logic [15:0][7:0] text;
  } lcd_wr_s;
  typedef enum logic [1:0] {
    SW_IDLE  = 2'b00,
    SW_PULSE = 2'b01,
    SW_HOLD  = 2'b11,
    SW_DONE  = 2'b10
  } sw_state_e;
endpackage : supervisor_pkg

// file: logic/host_power_watchdog_supervisor.sv
// Host power switch, watchdog, readback, text and GPIO supervisor
//
// Contract
// - Blank display, backlight off while host down
// - Sense source 1 internal, 0 GPIO pin 1
// - Stay active; reboot when host power returns
// - Mask bits: auto polarity, reset/power invert
// - Mask bits enable keypad reset, on, off
// - Pulse length in 1/32 s, 1 to 255
// - One to three bytes; omitted keep defaults (code keeps the values last set, not the reset values)
// - Watchdog timeout zero disables it
// - Expiry resets host, watchdog stays off
// - Watchdog disabled after power-up
// - Readback answers fifteen bytes, type 0x5E
// - Bytes 7, 8, 11: mask, counter, source
// - Text write: column, row, 1-16 characters
// - Acknowledge at old rate, then switch
// - Link starts at 19200 unless boot stored
// - Five pins: input, level or 100 Hz PWM
// - Sample all pins at 32 Hz
// - Sticky edge flags, cleared on query
// - Switch outputs Hi-Z except during pulse
// - Hold confirm 4 s: 1 s reset, reboot
`timescale 1ns/10ps
`default_nettype none
module host_power_watchdog_supervisor
  import supervisor_pkg::*;
#(
  parameter int TICK_CYC_P = supervisor_pkg::TICK_CYC,
  parameter int STEP_CYC_P = supervisor_pkg::PWM_STEP_CYC,
  parameter int GPIO_N     = 5
)(
  input  wire logic                    CLK_SYS,
  input  wire logic                    RST_N,
  input  wire logic                    CMD_VALID,
  input  wire supervisor_pkg::cmd_s    CMD,
  output logic                         CMD_READY,
  output logic                         RSP_VALID,
  output supervisor_pkg::rsp_s         RSP,
  input  wire logic                    RSP_READY,
  input  wire logic                    TX_IDLE,
  input  wire logic [7:0]              BOOT_BAUD,
  output logic [7:0]                   BAUD_CODE,
  input  wire supervisor_pkg::misc_s   MISC,
  input  wire logic                    HOST_SENSE_INT,
  input  wire logic                    KEY_CONFIRM,
  input  wire logic                    KEY_CANCEL,
  input  wire logic [GPIO_N-1:0]       GPIO_IN,
  output logic [GPIO_N-1:0]            GPIO_OUT,
  output logic [GPIO_N-1:0]            GPIO_OE_N,
  output logic                         LCD_BLANK,
  output logic                         BACKLIGHT_OFF,
  output logic                         LCD_WR_VALID,
  output supervisor_pkg::lcd_wr_s      LCD_WR,
  output logic                         SELF_REBOOT
);
  import supervisor_pkg::*;

  // ---------------------------------------------------------------
  // Timebase: 32 Hz tick and PWM phase
  // ---------------------------------------------------------------
  logic [31:0] tick_cnt_q, tick_cnt_d, step_cnt_q, step_cnt_d;
  logic [6:0]  phase_q, phase_d;
  logic        tick, step;
  assign tick = (tick_cnt_q == 32'(TICK_CYC_P - 1));
  assign step = (step_cnt_q == 32'(STEP_CYC_P - 1));
  always_comb
  begin
    tick_cnt_d = tick ? 32'h0 : tick_cnt_q + 32'h1;
    step_cnt_d = step ? 32'h0 : step_cnt_q + 32'h1;
    phase_d    = phase_q;
    if (step)
      phase_d = (phase_q == PWM_LAST) ? 7'h00 : phase_q + 7'h01;
  end
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      tick_cnt_q <= 32'h0;
      step_cnt_q <= 32'h0;
      phase_q    <= 7'h00;
    end
    else
    begin
      tick_cnt_q <= tick_cnt_d;
      step_cnt_q <= step_cnt_d;
      phase_q    <= phase_d;
    end
  end

  // ---------------------------------------------------------------
  // Shared state declarations
  // ---------------------------------------------------------------
  logic [7:0]              sw_mask_q, sw_mask_d, pulse_len_q, pulse_len_d;
  logic                    src_q, src_d;
  logic [7:0]              wd_q, wd_d;
  logic [4:0]              sec_q, sec_d;
  logic [GPIO_N-1:0][6:0]  lvl_q, lvl_d;
  logic [GPIO_N-1:0][3:0]  cfg_q, cfg_d;
  logic [GPIO_N-1:0]       smp_q, smp_d, rise_q, rise_d, fall_q, fall_d;
  logic [GPIO_N-1:0]       flag_clr;
  sw_state_e               st_q, st_d;
  logic [7:0]              pcnt_q, pcnt_d, ok_q, ok_d, x_q, x_d;
  logic                    is_rst_q, is_rst_d, reboot_q, reboot_d;
  logic                    ext_q, ext_d, lock_q, lock_d, pol_q, pol_d;
  logic                    sense, sense_q, sense_rise, reboot_go, wd_fire;
  logic                    accept, pulsing;

  assign sense      = src_q ? HOST_SENSE_INT : GPIO_IN[PIN_SENSE];
  assign sense_rise = sense & ~sense_q;
  assign pulsing    = (st_q == SW_PULSE) || (st_q == SW_HOLD);
  assign reboot_go  = ((st_q == SW_DONE) && reboot_q) || sense_rise;

  // ---------------------------------------------------------------
  // Command decode, configuration, watchdog, link rate
  // ---------------------------------------------------------------
  rsp_s       rsp_q, rsp_d;
  lcd_wr_s    lcd_q, lcd_d;
  logic       rsp_pend_q, rsp_pend_d, lcd_v_q, lcd_v_d;
  logic       bpend_q, bpend_d, boot_q, boot_d;
  logic [7:0] baud_q, baud_d, bnew_q, bnew_d, d0, d1, d2;
  logic [2:0] gi;

  assign CMD_READY = ~rsp_pend_q & ~lock_q & ~bpend_q & boot_q;
  assign accept    = CMD_VALID & CMD_READY;
  assign d0 = CMD.data[0];
  assign d1 = CMD.data[1];
  assign d2 = CMD.data[2];
  assign gi = d0[2:0];
  assign wd_fire = tick && (sec_q == SEC_TK) && (wd_q == 8'h01) &&
                   !(accept && CMD.kind == CMD_WDOG);

  always_comb
  begin
    sw_mask_d = sw_mask_q;
    pulse_len_d = pulse_len_q;
    src_d = src_q;
    wd_d = wd_q;
    sec_d = sec_q;
    lvl_d = lvl_q;
    cfg_d = cfg_q;
    rsp_d = rsp_q;
    lcd_d = lcd_q;
    lcd_v_d = 1'b0;
    rsp_pend_d = rsp_pend_q & ~RSP_READY;
    bpend_d = bpend_q;
    bnew_d = bnew_q;
    baud_d = baud_q;
    boot_d = 1'b1;
    flag_clr = '0;
    if (!boot_q)
      baud_d = BOOT_BAUD;
    if (bpend_q && !rsp_pend_q && TX_IDLE)
    begin
      baud_d  = bnew_q;
      bpend_d = 1'b0;
    end
    if (tick && wd_q != 8'h00)
    begin
      sec_d = (sec_q == SEC_TK) ? 5'h00 : sec_q + 5'h01;
      if (sec_q == SEC_TK)
        wd_d = wd_q - 8'h01;
    end
    if (accept)
    begin
      rsp_pend_d = 1'b1;
      rsp_d      = '0;
      rsp_d.kind = CMD.kind | RSP_ACK;
      unique case (CMD.kind)
        CMD_SWITCH:
          if (CMD.len >= 5'h01 && CMD.len <= 5'h03)
          begin
            sw_mask_d = d0;
            if (CMD.len >= 5'h02 && d1 != 8'h00)
              pulse_len_d = d1;
            if (CMD.len == 5'h03)
              src_d = d2[0];
          end
          else
            rsp_d.kind = CMD.kind | RSP_ERR;
        CMD_WDOG:
          if (CMD.len == 5'h01)
          begin
            wd_d  = d0;
            sec_d = 5'h00;
          end
          else
            rsp_d.kind = CMD.kind | RSP_ERR;
        CMD_READBACK:
        begin
          rsp_d.len = RB_LEN;
          rsp_d.data[1] = MISC.temp_mask[0];
          rsp_d.data[2] = MISC.temp_mask[1];
          rsp_d.data[3] = MISC.temp_mask[2];
          rsp_d.data[4] = MISC.temp_mask[3];
          rsp_d.data[5] = MISC.key_press;
          rsp_d.data[6] = MISC.key_release;
          rsp_d.data[RB_IDX_MASK] = sw_mask_q;
          rsp_d.data[RB_IDX_WD]   = wd_q;
          rsp_d.data[RB_IDX_SRC]  = {7'h00, src_q};
          rsp_d.data[9]  = MISC.user_contrast;
          rsp_d.data[10] = MISC.key_backlight;
          rsp_d.data[13] = MISC.contrast;
          rsp_d.data[14] = MISC.lcd_backlight;
        end
        CMD_TEXT:
          if (CMD.len >= TEXT_MIN && CMD.len <= TEXT_MAX &&
              d0 <= COL_MAX && d1 <= ROW_MAX)
          begin
            lcd_v_d   = 1'b1;
            lcd_d.col = d0[3:0];
            lcd_d.row = d1[0];
            lcd_d.count = CMD.len - 5'h02;
            lcd_d.text  = CMD.data[17:2];
          end
          else
            rsp_d.kind = CMD.kind | RSP_ERR;
        CMD_BAUD:
          if (CMD.len == 5'h01)
          begin
            bpend_d = 1'b1;
            bnew_d  = d0;
          end
          else
            rsp_d.kind = CMD.kind | RSP_ERR;
        CMD_GPIO_SET:
          if ((CMD.len == 5'h02 || (CMD.len == 5'h03 && d2 <= CFG_MAX)) &&
              d0 < 8'(GPIO_N) && d1 <= LVL_MAX)
          begin
            lvl_d[gi] = d1[6:0];
            if (CMD.len == 5'h03)
              cfg_d[gi] = d2[3:0];
          end
          else
            rsp_d.kind = CMD.kind | RSP_ERR;
        CMD_GPIO_GET:
          if (CMD.len == 5'h01 && d0 < 8'(GPIO_N))
          begin
            rsp_d.len     = GET_LEN;
            rsp_d.data[0] = d0;
            rsp_d.data[1] = {5'h00, rise_q[gi], fall_q[gi], smp_q[gi]};
            rsp_d.data[2] = {1'b0, lvl_q[gi]};
            rsp_d.data[3] = {4'h0, cfg_q[gi]};
            flag_clr[gi]  = 1'b1;
          end
          else
            rsp_d.kind = CMD.kind | RSP_ERR;
        default:
          rsp_d.kind = CMD.kind | RSP_ERR;
      endcase
    end
    if (reboot_go)
    begin
      wd_d  = 8'h00;
      sec_d = 5'h00;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      sw_mask_q <= SW_MASK_RST;
      pulse_len_q <= PULSE_RST;
      src_q <= SRC_RST;
      wd_q <= 8'h00;
      sec_q <= 5'h00;
      lvl_q <= '0;
      cfg_q <= {GPIO_N{GPIO_CFG_RST}};
      rsp_q <= '0;
      lcd_q <= '0;
      lcd_v_q <= 1'b0;
      rsp_pend_q <= 1'b0;
      bpend_q <= 1'b0;
      bnew_q <= 8'h00;
      baud_q <= 8'h00;
      boot_q <= 1'b0;
    end
    else
    begin
      sw_mask_q <= sw_mask_d;
      pulse_len_q <= pulse_len_d;
      src_q <= src_d;
      wd_q <= wd_d;
      sec_q <= sec_d;
      lvl_q <= lvl_d;
      cfg_q <= cfg_d;
      rsp_q <= rsp_d;
      lcd_q <= lcd_d;
      lcd_v_q <= lcd_v_d;
      rsp_pend_q <= rsp_pend_d;
      bpend_q <= bpend_d;
      bnew_q <= bnew_d;
      baud_q <= baud_d;
      boot_q <= boot_d;
    end
  end
  assign RSP_VALID    = rsp_pend_q;
  assign RSP          = rsp_q;
  assign BAUD_CODE    = baud_q;
  assign LCD_WR_VALID = lcd_v_q;
  assign LCD_WR       = lcd_q;

  // ---------------------------------------------------------------
  // Switch pulse sequencer and keypad hold timers
  // ---------------------------------------------------------------
  logic trig_rst, trig_on, trig_off, blank_d, blank_q, srb_q;
  assign trig_rst = tick && KEY_CONFIRM && sense && sw_mask_q[SW_KEY_RST] &&
                    ok_q == HOLD_LONG_TK - 8'h01;
  assign trig_on  = tick && KEY_CONFIRM && !sense && sw_mask_q[SW_KEY_ON] &&
                    ok_q == HOLD_SHORT_TK - 8'h01;
  assign trig_off = tick && KEY_CANCEL && sense && sw_mask_q[SW_KEY_OFF] &&
                    x_q == HOLD_LONG_TK - 8'h01;
  assign blank_d  = sw_mask_q[SW_BLANK] & ~sense;

  always_comb
  begin
    st_d = st_q;
    pcnt_d = pcnt_q;
    is_rst_d = is_rst_q;
    reboot_d = reboot_q;
    ext_d = ext_q;
    lock_d = lock_q;
    pol_d = pol_q;
    ok_d = ok_q;
    x_d = x_q;
    if (!KEY_CONFIRM)
      ok_d = 8'h00;
    else if (tick && ok_q != 8'hFF)
      ok_d = ok_q + 8'h01;
    if (!KEY_CANCEL)
      x_d = 8'h00;
    else if (tick && x_q != 8'hFF)
      x_d = x_q + 8'h01;
    unique case (st_q)
      SW_IDLE:
        if (wd_fire || trig_rst || trig_on || trig_off)
        begin
          st_d     = SW_PULSE;
          is_rst_d = wd_fire || trig_rst;
          pcnt_d   = (wd_fire || trig_rst) ? RST_PULSE_TK : pulse_len_q;
          reboot_d = !wd_fire && (trig_rst || trig_on);
          lock_d   = !wd_fire && trig_rst;
          ext_d    = !wd_fire && !trig_rst && !trig_on;
          // Auto mode drives against the idle level seen on the pin
          if (sw_mask_q[SW_AUTO_POL])
            pol_d = (wd_fire || trig_rst) ? ~smp_q[PIN_RST] : ~smp_q[PIN_PWR];
          else
            pol_d = (wd_fire || trig_rst) ? sw_mask_q[SW_RST_INV]
                                          : sw_mask_q[SW_PWR_INV];
        end
      SW_PULSE:
        if (tick)
        begin
          pcnt_d = pcnt_q - 8'h01;
          if (pcnt_q == 8'h01)
          begin
            st_d   = (ext_q && KEY_CANCEL) ? SW_HOLD : SW_DONE;
            pcnt_d = EXTEND_TK;
          end
        end
      SW_HOLD:
        if (!KEY_CANCEL || (tick && pcnt_q == 8'h01))
          st_d = SW_DONE;
        else if (tick)
          pcnt_d = pcnt_q - 8'h01;
      SW_DONE:
      begin
        st_d   = SW_IDLE;
        lock_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      st_q <= SW_IDLE;
      pcnt_q <= 8'h00;
      is_rst_q <= 1'b0;
      reboot_q <= 1'b0;
      ext_q <= 1'b0;
      lock_q <= 1'b0;
      pol_q <= 1'b0;
      ok_q <= 8'h00;
      x_q <= 8'h00;
      sense_q <= 1'b0;
      blank_q <= 1'b0;
      srb_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      pcnt_q <= pcnt_d;
      is_rst_q <= is_rst_d;
      reboot_q <= reboot_d;
      ext_q <= ext_d;
      lock_q <= lock_d;
      pol_q <= pol_d;
      ok_q <= ok_d;
      x_q <= x_d;
      sense_q <= sense;
      blank_q <= blank_d;
      srb_q <= reboot_go;
    end
  end
  assign LCD_BLANK     = blank_q;
  assign BACKLIGHT_OFF = blank_q;
  assign SELF_REBOOT   = srb_q;

  // ---------------------------------------------------------------
  // GPIO sampling, edge flags and pin drive
  // ---------------------------------------------------------------
  logic [GPIO_N-1:0] out_d, out_q, oen_d, oen_q;
  always_comb
  begin
    smp_d  = tick ? GPIO_IN : smp_q;
    // A new edge wins over a clear in the same cycle
    rise_d = (rise_q & ~flag_clr) | ({GPIO_N{tick}} & GPIO_IN & ~smp_q);
    fall_d = (fall_q & ~flag_clr) | ({GPIO_N{tick}} & ~GPIO_IN & smp_q);
    for (int i = 0; i < GPIO_N; i++)
    begin
      out_d[i] = 1'b0;
      oen_d[i] = 1'b1;
      if (cfg_q[i][CFG_USER] && cfg_q[i][2:0] != DRV_HIZ)
      begin
        oen_d[i] = 1'b0;
        out_d[i] = (phase_q < lvl_q[i]);
      end
      else if (!cfg_q[i][CFG_USER] && pulsing &&
               ((i == PIN_RST && is_rst_q) || (i == PIN_PWR && !is_rst_q)))
      begin
        oen_d[i] = 1'b0;
        out_d[i] = pol_q;
      end
    end
  end
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      smp_q  <= '0;
      rise_q <= '0;
      fall_q <= '0;
      out_q  <= '0;
      oen_q  <= '1;
    end
    else
    begin
      smp_q  <= smp_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
      out_q  <= out_d;
      oen_q  <= oen_d;
    end
  end
  assign GPIO_OUT  = out_q;
  assign GPIO_OE_N = oen_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence reset_pulse_s;
    (st_q == SW_PULSE && is_rst_q)[*8];
  endsequence
  blank_follow_a:
    assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (sw_mask_q[SW_BLANK] && !sense) |=> (LCD_BLANK && BACKLIGHT_OFF))
    else $error("display not blanked with host down");
  wd_zero_a:
    assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (accept && CMD.kind == CMD_WDOG && CMD.len == 5'h01 && d0 == 8'h00)
      |=> (wd_q == 8'h00) [*2])
    else $error("watchdog not disabled by zero timeout");
  wd_expire_a:
    assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      wd_fire |=> (wd_q == 8'h00 && st_q == SW_PULSE && is_rst_q))
    else $error("watchdog expiry did not start host reset");
  rst_pulse_a:
    assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (st_q == SW_IDLE && trig_rst && !wd_fire) |=> reset_pulse_s)
    else $error("keypad reset pulse not held");
  readback_a:
    assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (accept && CMD.kind == CMD_READBACK) |=>
      (RSP_VALID && RSP.kind == 8'h5E && RSP.len == RB_LEN &&
       RSP.data[0] == 8'h00 && RSP.data[12] == 8'h00))
    else $error("readback response malformed");
  rb_fields_a:
    assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (accept && CMD.kind == CMD_READBACK) |=>
      (RSP.data[RB_IDX_MASK] == $past(sw_mask_q) &&
       RSP.data[RB_IDX_WD] == $past(wd_q) &&
       RSP.data[RB_IDX_SRC][0] == $past(src_q)))
    else $error("readback fields wrong");
  baud_order_a:
    assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (boot_q && $changed(BAUD_CODE)) |-> $past(!rsp_pend_q && TX_IDLE))
    else $error("link rate changed before acknowledgement sent");
  idle_hiz_a:
    assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (st_q == SW_IDLE && $past(st_q) == SW_IDLE &&
       !cfg_q[PIN_RST][CFG_USER]) |-> GPIO_OE_N[PIN_RST])
    else $error("reset output driven while idle");
  ack_type_a:
    assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (accept && CMD.kind == CMD_SWITCH && CMD.len == 5'h01) |=>
      (RSP_VALID && RSP.kind == 8'h5C && RSP.len == 5'h00))
    else $error("switch command not acknowledged");
  edge_clear_a:
    assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (accept && CMD.kind == CMD_GPIO_GET && CMD.len == 5'h01 &&
       d0 == 8'h00 && !tick) |=> !rise_q[0] && !fall_q[0])
    else $error("edge flags not cleared by query");
  reboot_wd_a:
    assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      sense_rise |=> (SELF_REBOOT && wd_q == 8'h00))
    else $error("no reboot on host power return");
endmodule : host_power_watchdog_supervisor
`default_nettype wire

// file: bench/host_link_model.sv
// Host side of the command link: takes answers, mimics serial send time
`timescale 1ns/10ps
`default_nettype none
module host_link_model #(
  parameter int LAG  = 2,
  parameter int SEND = 6
)(
  input  wire logic clk,
  input  wire logic rsp_valid,
  output logic      rsp_ready,
  output logic      tx_idle
);
  int wait_c = 0;
  int busy_c = 0;
  initial rsp_ready = 1'b0;
  initial tx_idle = 1'b1;
  // Slow taker; the ack must be read before the link may retune
  always @(negedge clk)
  begin
    if (rsp_ready && !rsp_valid) busy_c = SEND;
    wait_c = rsp_valid ? wait_c + 1 : 0;
    rsp_ready = rsp_valid && wait_c > LAG;
    tx_idle = (busy_c == 0);
    if (busy_c > 0) busy_c--;
  end
endmodule : host_link_model
`default_nettype wire

// file: bench/host_power_watchdog_supervisor_tb_top.sv
// Command-level bench for the host power and watchdog supervisor
`timescale 1ns/10ps
`default_nettype none
module host_power_watchdog_supervisor_tb_top;
  import supervisor_pkg::*;
  logic CLK_SYS, RST_N, CMD_VALID, CMD_READY, RSP_VALID, RSP_READY;
  logic TX_IDLE, HOST_SENSE_INT, LCD_BLANK, BACKLIGHT_OFF;
  logic LCD_WR_VALID, SELF_REBOOT, boot_seen, KEY_CONFIRM, KEY_CANCEL;
  logic [7:0] BAUD_CODE;
  logic [4:0] GPIO_OUT, GPIO_OE_N, GPIO_IN;
  cmd_s CMD;
  rsp_s RSP, r;
  lcd_wr_s LCD_WR, lw;
  int fail_count = 0;
  int checks_done = 0;
  int k;
  host_power_watchdog_supervisor #(.TICK_CYC_P(8), .STEP_CYC_P(2)) DUT (
    .CLK_SYS(CLK_SYS), .RST_N(RST_N), .CMD_VALID(CMD_VALID), .CMD(CMD),
    .CMD_READY(CMD_READY), .RSP_VALID(RSP_VALID), .RSP(RSP),
    .RSP_READY(RSP_READY), .TX_IDLE(TX_IDLE), .BOOT_BAUD(8'h00),
    .BAUD_CODE(BAUD_CODE), .MISC('0), .HOST_SENSE_INT(HOST_SENSE_INT),
    .KEY_CONFIRM(KEY_CONFIRM), .KEY_CANCEL(KEY_CANCEL), .GPIO_IN(GPIO_IN),
    .GPIO_OUT(GPIO_OUT), .GPIO_OE_N(GPIO_OE_N), .LCD_BLANK(LCD_BLANK),
    .BACKLIGHT_OFF(BACKLIGHT_OFF), .LCD_WR_VALID(LCD_WR_VALID),
    .LCD_WR(LCD_WR), .SELF_REBOOT(SELF_REBOOT));
  host_link_model HOST (.clk(CLK_SYS), .rsp_valid(RSP_VALID),
    .rsp_ready(RSP_READY), .tx_idle(TX_IDLE));
  task summarize;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask : chk
  // Bounded waits; running out counts as a mismatch
  task send(input logic [7:0] kd, input logic [4:0] ln,
            input logic [31:0] d, input logic [7:0] ek);
    @(negedge CLK_SYS);
    CMD = '0;
    CMD.kind = kd;
    CMD.len = ln;
    CMD.data[3:0] = d;
    CMD_VALID = 1'b1;
    for (k = 0; k < 300 && CMD_READY !== 1'b1; k++) @(negedge CLK_SYS);
    chk(8'(CMD_READY), 8'h01);
    if (CMD_READY !== 1'b1) summarize();
    @(negedge CLK_SYS);
    CMD_VALID = 1'b0;
    for (k = 0; k < 300 && RSP_VALID !== 1'b1; k++) @(negedge CLK_SYS);
    chk(8'(RSP_VALID), 8'h01);
    r = RSP;
    chk(r.kind, ek);
    // Wait out the handshake so the next request follows it
    for (k = 0; k < 300 && RSP_VALID !== 1'b0; k++) @(negedge CLK_SYS);
    chk(8'(RSP_VALID), 8'h00);
  endtask : send
  initial
  begin
    CLK_SYS = 1'b0;
    forever #2 CLK_SYS = ~CLK_SYS;
  end
  always @(negedge CLK_SYS)
  begin
    if (LCD_WR_VALID) lw = LCD_WR;
    if (SELF_REBOOT) boot_seen = 1'b1;
  end
  initial
  begin
    RST_N = 0;
    CMD_VALID = 0;
    CMD = '0;
    HOST_SENSE_INT = 1;
    KEY_CONFIRM = 0;
    KEY_CANCEL = 0;
    GPIO_IN = '0;
    lw = '0;
    repeat (3) @(negedge CLK_SYS);
    RST_N = 1;
    repeat (4) @(negedge CLK_SYS);
    chk(BAUD_CODE, 8'h00);
    send(CMD_READBACK, 0, 0, 8'h5E);
    chk(8'(r.len), 8'h0F);
    chk(r.data[0], 8'h00);
    chk(r.data[8], 8'h00);
    chk(r.data[11], 8'h01);
    $display("test defaults done");
    send(CMD_SWITCH, 3, 32'h01_08_16, 8'h5C);
    send(CMD_SWITCH, 1, 32'h10, 8'h5C);
    send(CMD_READBACK, 0, 0, 8'h5E);
    chk(r.data[7], 8'h10);
    chk(r.data[11], 8'h01);
    boot_seen = 0;
    HOST_SENSE_INT = 0;
    repeat (4) @(negedge CLK_SYS);
    chk(8'(LCD_BLANK), 8'h01);
    chk(8'(BACKLIGHT_OFF), 8'h01);
    HOST_SENSE_INT = 1;
    repeat (4) @(negedge CLK_SYS);
    chk(8'(LCD_BLANK), 8'h00);
    chk(8'(boot_seen), 8'h01);
    $display("test switch and blank done");
    send(CMD_WDOG, 1, 32'h03, 8'h5D);
    send(CMD_READBACK, 0, 0, 8'h5E);
    chk(r.data[8], 8'h03);
    send(CMD_WDOG, 1, 32'h00, 8'h5D);
    send(CMD_READBACK, 0, 0, 8'h5E);
    chk(r.data[8], 8'h00);
    send(CMD_WDOG, 1, 32'h01, 8'h5D);
    for (k = 0; k < 400 && GPIO_OE_N[3] !== 1'b0; k++) @(negedge CLK_SYS);
    chk(8'(GPIO_OE_N[3]), 8'h00);
    chk(8'(GPIO_OUT[3]), 8'h00);
    repeat (300) @(negedge CLK_SYS);
    chk(8'(GPIO_OE_N[3]), 8'h01);
    send(CMD_READBACK, 0, 0, 8'h5E);
    chk(r.data[8], 8'h00);
    $display("test watchdog done");
    send(CMD_TEXT, 4, 32'h42_41_01_0F, 8'h5F);
    chk(8'(lw.col), 8'h0F);
    chk(8'(lw.row), 8'h01);
    chk(8'(lw.count), 8'h02);
    chk(lw.text[1], 8'h42);
    send(CMD_TEXT, 3, 32'h41_00_10, 8'hDF);
    $display("test text done");
    send(CMD_BAUD, 1, 32'h05, 8'h61);
    chk(BAUD_CODE, 8'h00);
    for (k = 0; k < 50 && BAUD_CODE !== 8'h05; k++) @(negedge CLK_SYS);
    chk(BAUD_CODE, 8'h05);
    $display("test baud done");
    GPIO_IN = 5'h01;
    repeat (10) @(negedge CLK_SYS);
    send(CMD_GPIO_GET, 1, 32'h00, 8'h63);
    chk(r.data[1], 8'h05);
    send(CMD_GPIO_GET, 1, 32'h00, 8'h63);
    chk(r.data[1], 8'h01);
    GPIO_IN = 5'h00;
    repeat (10) @(negedge CLK_SYS);
    send(CMD_GPIO_GET, 1, 32'h00, 8'h63);
    chk(r.data[1], 8'h02);
    send(CMD_GPIO_SET, 3, 32'h09_64_04, 8'h62);
    chk(8'(GPIO_OE_N[4]), 8'h00);
    chk(8'(GPIO_OUT[4]), 8'h01);
    $display("test gpio done");
    send(CMD_SWITCH, 1, 32'h20, 8'h5C);
    boot_seen = 0;
    KEY_CONFIRM = 1;
    for (k = 0; k < 1200 && GPIO_OE_N[3] !== 1'b0; k++) @(negedge CLK_SYS);
    chk(8'(GPIO_OE_N[3]), 8'h00);
    chk(8'(CMD_READY), 8'h00);
    KEY_CONFIRM = 0;
    for (k = 0; k < 300 && GPIO_OE_N[3] !== 1'b1; k++) @(negedge CLK_SYS);
    chk(8'(k / 8), RST_PULSE_TK);
    @(negedge CLK_SYS);
    chk(8'(boot_seen), 8'h01);
    $display("test keypad done");
    summarize();
  end
endmodule : host_power_watchdog_supervisor_tb_top
`default_nettype wire
